// ===== core/dac_ctrl_pkg.sv
// Shared constants and types for the quad converter update control
package dac_ctrl_pkg;
  // Converter code width, one of 16, 14 or 12
  localparam int CODE_WIDTH = 16;
  localparam int NUM_CH = 4;
  // Serial frame layout
  localparam int FRAME_BITS = 24;
  localparam int FRAME_RW_BIT = 23;
  localparam int FRAME_ADDR_MSB = 19;
  localparam int FRAME_ADDR_LSB = 16;
  // Register addresses
  localparam logic [3:0] ADDR_UPDATE_CTRL = 4'h2;
  localparam logic [3:0] ADDR_CONFIG = 4'h3;
  localparam logic [3:0] ADDR_GAIN = 4'h4;
  localparam logic [3:0] ADDR_TRIGGER = 4'h5;
  localparam logic [3:0] ADDR_BROADCAST = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_DATA0 = 4'h8;
  // Field positions
  localparam int UPD_DEFER_LSB = 0;
  localparam int UPD_BCAST_LSB = 8;
  localparam int CFG_REF_EN_BIT = 0;
  localparam int CFG_ALARM_PIN_ENABLE_BIT = 1;
  localparam int CFG_ALARM_SOURCE_SELECT_BIT = 2;
  localparam int GAIN_CH_LSB = 0;
  localparam int GAIN_DIVIDE_SELECT_PIN_BIT = 8;
  localparam int TRIG_LOAD_BIT = 4;
  localparam int STATUS_ALARM_BIT = 0;
  // Reset values and command codes
  localparam logic [15:0] UPDATE_CTRL_RESET = 16'h0F00;
  localparam logic [15:0] CONFIG_RESET = 16'h0001;
  localparam logic [15:0] SOFT_RESET_CODE = 16'h1010;
  // Timing
  localparam int POR_DELAY_US = 250;
  localparam int CORE_CLK_MHZ = 40;
  localparam int POR_CYCLES = POR_DELAY_US * CORE_CLK_MHZ;
  // Types
  typedef logic [CODE_WIDTH-1:0] code_type;
  typedef enum {ST_POR_WAIT, ST_READY} core_state_type;
endpackage

// ===== core/frame_link_if.sv
// Frame carrier between the serial link logic and the core logic
`timescale 1ns/100ps
interface frame_link_if;
  logic [23:0] frame_word; // Last 24 bits shifted in
  logic frame_full; // At least 24 falling edges seen
  logic sdo_bit; // Serial readback bit
  logic [23:0] reply_word; // Word to shift out next frame
  modport link (output frame_word, output frame_full, output sdo_bit, input reply_word);
  modport core (input frame_word, input frame_full, input sdo_bit, output reply_word);
endinterface

// ===== core/serial_frame_link.sv
// Serial link shift logic on the serial clock domain
`timescale 1ns/100ps
module serial_frame_link
  import dac_ctrl_pkg::*;
(
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  frame_link_if.link lnk
);
  // ------------------------------------------------------------
  // Input shift and edge count
  // ------------------------------------------------------------
  logic [23:0] shift_ff; // Keeps only the final 24 bits
  logic [4:0] count_ff; // Saturating edge count
  logic full_ff; // Frame reached 24 falling edges, held while deselected

  // Count cleared by the frame's own chip select, no clock needed
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      count_ff <= 5'h00;
    end else if (count_ff != 5'(FRAME_BITS)) begin
      count_ff <= count_ff + 5'h01;
    end
  end

  // Count is cleared at chip select rise, so the flag keeps the verdict
  // Hazard: a frame with no clock edges leaves the old verdict standing
  always_ff @(negedge sclk) begin
    if (!cs_n) begin
      full_ff <= (count_ff >= 5'(FRAME_BITS - 1));
    end
  end

  // Data taken on falling edges while selected
  always_ff @(negedge sclk) begin
    if (!cs_n) begin
      shift_ff <= {shift_ff[22:0], sdi};
    end
  end

  // Readback driven on rising edges, sampled by host on falling
  always_ff @(posedge sclk) begin
    if (count_ff < 5'(FRAME_BITS)) begin
      lnk.sdo_bit <= lnk.reply_word[5'(FRAME_BITS - 1) - count_ff];
    end else begin
      lnk.sdo_bit <= 1'b0;
    end
  end

  assign lnk.frame_word = shift_ff;
  assign lnk.frame_full = full_ff;
endmodule

// ===== core/load_edge_detect.sv
// Synchroniser and falling edge detector for the load trigger pin
`timescale 1ns/100ps
module load_edge_detect (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pin,
  output logic fall_pulse
);
  // ------------------------------------------------------------
  // Two stage synchroniser, then edge history
  // ------------------------------------------------------------
  logic sync1_ff; // First stage, read only by second
  logic sync2_ff; // Second stage
  logic hist_ff; // Previous synchronised level

  // Pin idles high
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      hist_ff <= 1'b1;
    end else begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
      hist_ff <= sync2_ff;
    end
  end

  // One cycle on a high to low change
  assign fall_pulse = hist_ff & ~sync2_ff;
endmodule

// ===== core/quad_dac_update_control.sv
// Register, update and reset control for the four channel converter
//
// Overview of operation
// - Channel codes are unsigned straight binary
// - Reset loads zero or midscale per pin
// - Code width is 16, 14 or 12
// - Divide factor from pin, then register bit
// - Per channel gain from pin, then register
// - Writes land in buffer, move later
// - Data reads return buffer, never active
// - Immediate channels update at frame end
// - Deferred channels update only on trigger or broadcast
// - One broadcast enable bit per channel
// - Broadcast loads enabled channels at frame end
// - Internal reference on until software clears
// - Divide by two via pin or bit
// - Alarm stops buffer, forces outputs zero
// - Alarm leaves data registers untouched
// - Alarm readable in status register
// - Alarm drives shared pin when selected
// - Power-on resets all, host waits 250us
// - Channels hold reset level until written
// - Soft reset code restarts power-on sequence
// - 24 falling edges per frame, last used
// - Bit 23 read, 19:16 address, 15:0 data
`timescale 1ns/100ps
module quad_dac_update_control
  import dac_ctrl_pkg::*;
#(
  parameter int POR_WAIT_CYCLES = dac_ctrl_pkg::POR_CYCLES
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic load_trigger,
  input wire logic reset_value_select_pin,
  input wire logic divide_select_pin,
  input wire logic gain_pin,
  input wire logic divider_fault,
  output logic serial_out_alarm_pin_o,
  output logic serial_out_alarm_pin_oe,
  output dac_ctrl_pkg::code_type channel_code_0,
  output dac_ctrl_pkg::code_type channel_code_1,
  output dac_ctrl_pkg::code_type channel_code_2,
  output dac_ctrl_pkg::code_type channel_code_3,
  output logic [3:0] channel_gain_two,
  output logic ref_div_two,
  output logic internal_ref_enable,
  output logic ref_buffer_enable,
  output logic reference_alarm_flag,
  output logic ready
);
  import dac_ctrl_pkg::*;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Register word to code, left justified
  function automatic code_type word_to_code(input logic [15:0] w);
    word_to_code = w[15 -: CODE_WIDTH];
  endfunction

  // Code back to a register word, low bits zero
  function automatic logic [15:0] code_to_word(input code_type c);
    code_to_word = 16'(c) << (16 - CODE_WIDTH);
  endfunction

  // ------------------------------------------------------------
  // Link logic and crossings
  // ------------------------------------------------------------
  frame_link_if lnk ();

  serial_frame_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .lnk(lnk.link)
  );

  logic load_pin_fall; // Synchronised load pin edge

  load_edge_detect u_load (
    .core_clk(core_clk),
    .reset(reset),
    .pin(load_trigger),
    .fall_pulse(load_pin_fall)
  );

  logic cs_sync1_ff; // First stage of chip select sync
  logic cs_sync2_ff; // Second stage
  logic cs_hist_ff; // Previous synced level
  logic fault_sync1_ff; // First stage of divider fault sync
  logic fault_sync2_ff; // Second stage
  logic rsel_sync1_ff; // Strap synchronisers
  logic rsel_sync2_ff;
  logic div_sync1_ff;
  logic div_sync2_ff;
  logic gain_sync1_ff;
  logic gain_sync2_ff;

  // Pins pass two flops before core logic reads them, except raw cs_n at the pin enable
  always_ff @(posedge core_clk) begin
    cs_sync1_ff <= cs_n;
    cs_sync2_ff <= cs_sync1_ff;
    cs_hist_ff <= cs_sync2_ff;
    fault_sync1_ff <= divider_fault;
    fault_sync2_ff <= fault_sync1_ff;
    rsel_sync1_ff <= reset_value_select_pin;
    rsel_sync2_ff <= rsel_sync1_ff;
    div_sync1_ff <= divide_select_pin;
    div_sync2_ff <= div_sync1_ff;
    gain_sync1_ff <= gain_pin;
    gain_sync2_ff <= gain_sync1_ff;
  end

  // ------------------------------------------------------------
  // Reset sequencing
  // ------------------------------------------------------------
  core_state_type state_ff; // Power-on wait or ready
  logic [13:0] por_cnt_ff; // Power-on delay counter
  logic soft_reset_ff; // Registered software reset request
  logic sys_rst; // Pin or software reset

  assign sys_rst = reset | soft_reset_ff;

  // Wait out the power-on delay before taking frames
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= ST_POR_WAIT;
      por_cnt_ff <= 14'(POR_WAIT_CYCLES - 1);
    end else begin
      case (state_ff)
        ST_POR_WAIT: begin
          if (por_cnt_ff == 14'h0000) begin
            state_ff <= ST_READY;
          end else begin
            por_cnt_ff <= por_cnt_ff - 14'h0001;
          end
        end
        ST_READY: begin
          state_ff <= ST_READY;
        end
        default: begin
          state_ff <= ST_POR_WAIT;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Frame decode
  // ------------------------------------------------------------
  logic cs_rise; // Frame end seen in core domain
  logic frame_take; // Complete frame accepted
  logic frame_rd; // Read command
  logic [3:0] frame_addr; // Register address
  logic [15:0] frame_data; // Write data
  logic wr_take; // Accepted write

  // Link words are static while chip select is high
  assign cs_rise = cs_sync2_ff & ~cs_hist_ff;
  assign frame_take = cs_rise & lnk.frame_full & (state_ff == ST_READY);
  assign frame_rd = lnk.frame_word[FRAME_RW_BIT];
  assign frame_addr = lnk.frame_word[FRAME_ADDR_MSB:FRAME_ADDR_LSB];
  assign frame_data = lnk.frame_word[15:0];
  assign wr_take = frame_take & ~frame_rd;

  // Software reset and load bit act once, then clear
  logic load_bit_pulse_ff; // Load bit trigger, one cycle
  logic load_evt; // Any load trigger

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      soft_reset_ff <= 1'b0;
      load_bit_pulse_ff <= 1'b0;
    end else begin
      soft_reset_ff <= wr_take && frame_addr == ADDR_TRIGGER && frame_data == SOFT_RESET_CODE;
      load_bit_pulse_ff <= wr_take && frame_addr == ADDR_TRIGGER && frame_data != SOFT_RESET_CODE
        && frame_data[TRIG_LOAD_BIT];
    end
  end

  assign load_evt = load_bit_pulse_ff | load_pin_fall;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [15:0] upd_ctrl_ff; // Deferred and broadcast enables
  logic [15:0] config_ff; // Reference and alarm pin control
  logic [3:0] gain_bits_ff; // Per channel gain of two
  logic ref_div_ff; // Divide reference by two

  // Straps are caught while reset is asserted
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      upd_ctrl_ff <= UPDATE_CTRL_RESET;
      config_ff <= CONFIG_RESET;
      gain_bits_ff <= {NUM_CH{gain_sync2_ff}};
      ref_div_ff <= div_sync2_ff;
    end else if (wr_take) begin
      case (frame_addr)
        ADDR_UPDATE_CTRL: begin
          upd_ctrl_ff <= frame_data;
        end
        ADDR_CONFIG: begin
          config_ff <= frame_data;
        end
        ADDR_GAIN: begin
          gain_bits_ff <= frame_data[GAIN_CH_LSB +: NUM_CH];
          ref_div_ff <= frame_data[GAIN_DIVIDE_SELECT_PIN_BIT];
        end
        default: begin
          upd_ctrl_ff <= upd_ctrl_ff;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Channel buffer and active registers
  // ------------------------------------------------------------
  code_type buffer_ff [NUM_CH]; // Host visible values
  code_type active_ff [NUM_CH]; // Values driving the outputs
  code_type reset_code; // Zero or midscale
  logic [3:0] defer_en; // Deferred update per channel
  logic [3:0] bcast_en; // Broadcast response per channel

  assign reset_code = rsel_sync2_ff ? code_type'(1 << (CODE_WIDTH - 1)) : '0;
  assign defer_en = upd_ctrl_ff[UPD_DEFER_LSB +: NUM_CH];
  assign bcast_en = upd_ctrl_ff[UPD_BCAST_LSB +: NUM_CH];

  // Trigger first, then a broadcast write in the same cycle overrides; a data write to a deferred channel only reaches the buffer
  always_ff @(posedge core_clk) begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (sys_rst) begin
        buffer_ff[ch] <= reset_code;
        active_ff[ch] <= reset_code;
      end else begin
        if (load_evt && defer_en[ch]) begin
          active_ff[ch] <= buffer_ff[ch];
        end
        if (wr_take && frame_addr == ADDR_DATA0 + 4'(ch)) begin
          buffer_ff[ch] <= word_to_code(frame_data);
          if (!defer_en[ch]) begin
            active_ff[ch] <= word_to_code(frame_data);
          end
        end
        if (wr_take && frame_addr == ADDR_BROADCAST && bcast_en[ch]) begin
          buffer_ff[ch] <= word_to_code(frame_data);
          active_ff[ch] <= word_to_code(frame_data);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Reference alarm and outputs
  // ------------------------------------------------------------
  logic alarm_ff; // Reference alarm condition
  logic alarm_pin_mode_ff; // Shared pin carries the alarm

  // Alarm forces outputs low but leaves the data registers alone
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alarm_ff <= 1'b0;
      alarm_pin_mode_ff <= 1'b0;
      channel_code_0 <= '0;
      channel_code_1 <= '0;
      channel_code_2 <= '0;
      channel_code_3 <= '0;
      ref_buffer_enable <= 1'b0;
    end else begin
      alarm_ff <= fault_sync2_ff;
      alarm_pin_mode_ff <= config_ff[CFG_ALARM_PIN_ENABLE_BIT] & config_ff[CFG_ALARM_SOURCE_SELECT_BIT];
      channel_code_0 <= alarm_ff ? '0 : active_ff[0];
      channel_code_1 <= alarm_ff ? '0 : active_ff[1];
      channel_code_2 <= alarm_ff ? '0 : active_ff[2];
      channel_code_3 <= alarm_ff ? '0 : active_ff[3];
      ref_buffer_enable <= ~alarm_ff;
    end
  end

  // Settings presented to the analog side
  always_ff @(posedge core_clk) begin
    if (reset) begin
      channel_gain_two <= 4'h0;
      ref_div_two <= 1'b0;
      internal_ref_enable <= 1'b1;
      reference_alarm_flag <= 1'b0;
      ready <= 1'b0;
    end else begin
      channel_gain_two <= gain_bits_ff;
      ref_div_two <= ref_div_ff;
      internal_ref_enable <= config_ff[CFG_REF_EN_BIT];
      reference_alarm_flag <= alarm_ff;
      ready <= (state_ff == ST_READY) & ~soft_reset_ff;
    end
  end

  // Shared pin: alarm level or serial readback
  assign serial_out_alarm_pin_o = alarm_pin_mode_ff ? alarm_ff : lnk.sdo_bit;
  assign serial_out_alarm_pin_oe = alarm_pin_mode_ff | ~cs_n;

  // ------------------------------------------------------------
  // Readback
  // ------------------------------------------------------------
  logic [15:0] rd_data; // Addressed register value
  logic [23:0] reply_ff; // Word for the next frame

  // Data addresses return buffer contents
  always_comb begin
    rd_data = 16'h0000;
    case (frame_addr)
      ADDR_UPDATE_CTRL: rd_data = upd_ctrl_ff;
      ADDR_CONFIG: rd_data = config_ff;
      ADDR_GAIN: rd_data = {7'h00, ref_div_ff, 4'h0, gain_bits_ff};
      ADDR_STATUS: rd_data = {15'h0000, alarm_ff};
      ADDR_DATA0: rd_data = code_to_word(buffer_ff[0]);
      ADDR_DATA0 + 4'h1: rd_data = code_to_word(buffer_ff[1]);
      ADDR_DATA0 + 4'h2: rd_data = code_to_word(buffer_ff[2]);
      ADDR_DATA0 + 4'h3: rd_data = code_to_word(buffer_ff[3]);
      default: rd_data = 16'h0000;
    endcase
  end

  // Echo header, then read data or echoed write data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reply_ff <= 24'h000000;
    end else if (frame_take) begin
      reply_ff <= {lnk.frame_word[23:16], frame_rd ? rd_data : frame_data};
    end
  end

  assign lnk.reply_word = reply_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_reset_value;
    sys_rst |=> active_ff[0] == $past(reset_code) && buffer_ff[3] == $past(reset_code);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset code not loaded");

  property p_immediate;
    wr_take && frame_addr == ADDR_DATA0 && !defer_en[0] && !sys_rst
      |=> active_ff[0] == word_to_code($past(frame_data));
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate update missing");

  property p_deferred_hold;
    !sys_rst && !load_evt && !wr_take |=> $stable(active_ff[1]);
  endproperty
  a_deferred_hold: assert property (p_deferred_hold) else $error("active changed without cause");

  property p_buffer_read;
    frame_take && frame_rd && frame_addr == ADDR_DATA0 + 4'h1 && !sys_rst
      |=> reply_ff[15:0] == code_to_word($past(buffer_ff[1]));
  endproperty
  a_buffer_read: assert property (p_buffer_read) else $error("read not from buffer");

  property p_broadcast;
    wr_take && frame_addr == ADDR_BROADCAST && bcast_en[2] && !sys_rst
      |=> active_ff[2] == word_to_code($past(frame_data));
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("broadcast not applied");

  sequence s_alarm_hold;
    alarm_ff [*2];
  endsequence
  property p_alarm_zero;
    s_alarm_hold ##0 !sys_rst |=> channel_code_0 == '0 && !ref_buffer_enable;
  endproperty
  a_alarm_zero: assert property (p_alarm_zero) else $error("alarm did not zero output");

  property p_alarm_flag;
    fault_sync2_ff && !sys_rst ##1 !sys_rst |=> reference_alarm_flag;
  endproperty
  a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag missing");

  sequence s_soft_cmd;
    wr_take && frame_addr == ADDR_TRIGGER && frame_data == SOFT_RESET_CODE && !sys_rst;
  endsequence
  property p_soft_reset;
    s_soft_cmd |=> soft_reset_ff ##1 state_ff == ST_POR_WAIT && !ready;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not started");

  property p_load_once;
    load_bit_pulse_ff |=> !load_bit_pulse_ff;
  endproperty
  a_load_once: assert property (p_load_once) else $error("load bit not self cleared");
endmodule

// ===== tb/spi_host_model.sv
// Host controller model driving the serial link of the converter
`timescale 1ns/100ps
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  // ----------------------------------------
  // Idle state
  // ----------------------------------------
  // Clock parked low and select high outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // ----------------------------------------
  // Frame transfer
  // ----------------------------------------
  // Sends the last n bits of w, MSB first, and collects readback
  task automatic xfer(input logic [31:0] w, input int n, output logic [23:0] rd);
    rd = 24'h000000;
    cs_n = 1'b0;
    #7;
    for (int i = n - 1; i >= 0; i--) begin
      #16 sclk = 1'b1;
      sdi = w[i];
      #16 rd = {rd[22:0], sdo};
      sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    sdi = ~sdi;
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the quad converter update control
`timescale 1ns/100ps
module tb;
  import dac_ctrl_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk, reset, load_trigger, divider_fault;
  logic sclk, cs_n, sdi, pin_o, pin_oe, div2, ref_en, buf_en, alarm, ready;
  logic [3:0] gain2;
  code_type c0, c1, c2, c3;
  logic [23:0] r;
  int num_errors = 0;
  int checks_done = 0;
  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  quad_dac_update_control #(.POR_WAIT_CYCLES(20)) quad_dac_update_control_i (
    .core_clk(core_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .load_trigger(load_trigger), .reset_value_select_pin(1'b1), .divide_select_pin(1'b1),
    .gain_pin(1'b1), .divider_fault(divider_fault), .serial_out_alarm_pin_o(pin_o),
    .serial_out_alarm_pin_oe(pin_oe), .channel_code_0(c0), .channel_code_1(c1),
    .channel_code_2(c2), .channel_code_3(c3), .channel_gain_two(gain2), .ref_div_two(div2),
    .internal_ref_enable(ref_en), .ref_buffer_enable(buf_en),
    .reference_alarm_flag(alarm), .ready(ready));
  spi_host_model spi_host_model_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(pin_o));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare one value
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Keeps one microsecond and more between updates
  task automatic gap();
    repeat (45) @(negedge core_clk);
  endtask
  // Register write frame
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    spi_host_model_i.xfer({12'h000, a, d}, 24, r);
    gap();
  endtask
  // Read frame followed by a second frame carrying the reply
  task automatic rd(input logic [3:0] a);
    spi_host_model_i.xfer({12'h008, a, 16'h0000}, 24, r);
    gap();
    spi_host_model_i.xfer({12'h008, a, 16'h0000}, 24, r);
    gap();
  endtask
  // Bounded wait for the power-on delay
  task automatic wait_ready();
    int n;
    for (n = 0; n < 200 && ready !== 1'b1; n++) @(negedge core_clk);
    chk({23'h0, ready}, 24'h000001);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Strap values and defaults after reset
  task automatic t_reset();
    wait_ready();
    chk({c0, c3[7:0]}, 24'h800000);
    chk({gain2, div2, ref_en, buf_en}, 24'h00007F);
  endtask
  // Immediate update of channel 0
  task automatic t_immediate();
    wr(ADDR_DATA0, 16'h1234);
    chk(c0, 24'h001234);
    chk(c1, 24'h008000);
  endtask
  // Deferred channel 1, readback and both triggers
  task automatic t_deferred();
    wr(ADDR_UPDATE_CTRL, 16'h0F02);
    wr(ADDR_DATA0 + 4'h1, 16'hABCD);
    chk(c1, 24'h008000);
    rd(ADDR_DATA0 + 4'h1);
    chk(r, 24'h89ABCD);
    load_trigger = 1'b0;
    repeat (8) @(negedge core_clk);
    chk(c1, 24'h00ABCD);
    load_trigger = 1'b1;
    wr(ADDR_DATA0 + 4'h1, 16'h5555);
    chk(c1, 24'h00ABCD);
    wr(ADDR_TRIGGER, 16'h0010);
    chk(c1, 24'h005555);
  endtask
  // Broadcast to channels 0 and 2 only
  task automatic t_broadcast();
    wr(ADDR_UPDATE_CTRL, 16'h0502);
    wr(ADDR_BROADCAST, 16'h0F0F);
    chk({c0, c2[7:0]}, 24'h0F0F0F);
    chk({c1, c3[15:8]}, 24'h555580);
  endtask
  // Long frame keeps its last bits, short frame is ignored
  task automatic t_framing();
    spi_host_model_i.xfer({8'h0F, 4'h0, ADDR_DATA0 + 4'h3, 16'h3333}, 28, r);
    gap();
    chk(c3, 24'h003333);
    spi_host_model_i.xfer({12'h000, ADDR_DATA0 + 4'h3, 16'h7777}, 20, r);
    gap();
    chk(c3, 24'h003333);
  endtask
  // Gain and divide from register
  task automatic t_gain();
    wr(ADDR_GAIN, 16'h000A);
    chk({gain2, div2}, 24'h000014);
    wr(ADDR_GAIN, 16'h0105);
    chk({gain2, div2}, 24'h00000B);
  endtask
  // Alarm forces outputs to zero and returns them
  task automatic t_alarm();
    wr(ADDR_CONFIG, 16'h0006);
    chk(ref_en, 24'h000000);
    divider_fault = 1'b1;
    repeat (8) @(negedge core_clk);
    chk({alarm, buf_en, pin_o, pin_oe}, 24'h00000B);
    chk({c0, c3[7:0]}, 24'h000000);
    rd(ADDR_STATUS);
    chk(r, 24'hFFFFFF);
    divider_fault = 1'b0;
    repeat (8) @(negedge core_clk);
    chk({c0, c3[7:0]}, 24'h0F0F33);
    chk({alarm, buf_en, pin_o}, 24'h000002);
    divider_fault = 1'b1;
    wr(ADDR_CONFIG, 16'h0001);
    rd(ADDR_STATUS);
    chk(r, 24'h870001);
    divider_fault = 1'b0;
    rd(ADDR_STATUS);
    chk(r, 24'h870000);
  endtask
  // Software reset code restarts the power-on sequence
  task automatic t_soft_reset();
    wr(ADDR_TRIGGER, SOFT_RESET_CODE);
    wait_ready();
    chk({c0, c1[15:8]}, 24'h800080);
    chk({gain2, div2, ref_en}, 24'h00003F);
    wr(ADDR_DATA0 + 4'h1, 16'h0042);
    chk(c1, 24'h000042);
  endtask
  // ----------------------------------------
  // Verdict and watchdog
  // ----------------------------------------
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_of_test();
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    load_trigger = 1'b1;
    divider_fault = 1'b0;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    t_reset();
    t_immediate();
    t_deferred();
    t_broadcast();
    t_framing();
    t_gain();
    t_alarm();
    t_soft_reset();
    end_of_test();
  end
endmodule
